// >>> core/dcd_regs.svh
// Constants for the DDR3 command decoder: field positions, encodings, counts.
// Assumes inclusion by bare name from the decoder files.
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

`define DCD_A_AP        10
`define DCD_A_BC        12
`define DCD_MR_BL_HI    1
`define DCD_MR_BL_LO    0
`define DCD_BL_FIXED8   2'h0
`define DCD_BL_OTF      2'h1
`define DCD_BL_FIXED4   2'h2
`define DCD_MR_SEL0     2'h0
`define DCD_MR_SEL1     2'h1
`define DCD_MR_SEL2     2'h2
`define DCD_MR1_RTT0    2
`define DCD_MR1_RTT1    6
`define DCD_MR1_RTT2    9
`define DCD_MR2_RTTW_HI 10
`define DCD_MR2_RTTW_LO 9
`define DCD_PAIRS_BL8   3'h4
`define DCD_PAIRS_BC4   3'h2
`define DCD_MR_RST      13'h0000
`define DCD_ROW_RST     13'h0000
`define DCD_MEM_AW      7
`define DCD_MEM_DW      32
`define DCD_MEM_DEPTH   128

`endif

// >>> core/dcd_pkg.sv
// Types shared by the DDR3 command decoder and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package dcd_pkg;

  typedef enum logic [4:0] {
    DCD_CMD_NONE,
    DCD_CMD_DES,
    DCD_CMD_NOP,
    DCD_CMD_ACT,
    DCD_CMD_PRE,
    DCD_CMD_PREA,
    DCD_CMD_WR,
    DCD_CMD_WRA,
    DCD_CMD_RD,
    DCD_CMD_RDA,
    DCD_CMD_MRS,
    DCD_CMD_REF,
    DCD_CMD_SRE,
    DCD_CMD_SRX,
    DCD_CMD_PDE,
    DCD_CMD_PDX,
    DCD_CMD_ZQCL,
    DCD_CMD_ZQCS
  } dcd_cmd_e;

  typedef enum logic [1:0] {
    DCD_PW_ACTIVE,
    DCD_PW_POWER_DOWN,
    DCD_PW_SELF_REFRESH
  } dcd_pwr_e;

endpackage

// >>> core/dcd_mem.sv
// Small data array for the decoder: one write port with byte enables, registered read.
// Assumes a single clock; contents are undefined until written.
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_mem (
  input  wire logic                    clk_in,
  input  wire logic                    we_in,
  input  wire logic [`DCD_MEM_AW-1:0]  waddr_in,
  input  wire logic [`DCD_MEM_DW-1:0]  wdata_in,
  input  wire logic [3:0]              wbe_in,
  input  wire logic [`DCD_MEM_AW-1:0]  raddr_in,
  output logic      [`DCD_MEM_DW-1:0]  rdata_out
);

  // One array per byte lane so each lane has a single writer
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      logic [7:0] lane [`DCD_MEM_DEPTH];
      always_ff @(posedge clk_in) begin
        if (we_in && wbe_in[g]) begin
          lane[waddr_in] <= wdata_in[g*8 +: 8];
        end
        rdata_out[g*8 +: 8] <= lane[raddr_in];
      end
    end
  endgenerate

endmodule

// >>> core/dcd_decoder.sv
// DDR3 device-side command decoder with bank state, mode registers, data path and ODT.
// Assumes command pins change on the link clock; core outputs run on CLK_IN.
//
// Behaviour
// - Data moves on both edges of the strobe, reads and writes.
// - Each byte lane of write data can be masked.
// - Registered high termination input enables termination on all data and strobes.
// - Termination input ignored when both mode registers disable termination.
// - Low device reset acts asynchronously; controller keeps it high normally.
// - Write: CS RAS/CAS/WE pattern, CKE high twice, bank active; A10 auto-precharge.
// - Read: same pattern with WE high, bank active; A10 auto-precharge.
// - On-the-fly mode: A12 low chops burst to four beats.
// - On-the-fly mode: A12 high gives full eight beats.
// - Mode register set when all strobes low, idle; bank picks register.
// - Refresh decoded with WE high while idle, CKE high twice.
// - CKE falling with refresh enters self-refresh; rising with no-op exits.
// - CKE falling with no-op or deselect while idle enters power-down.
// - CKE rising with no-op or deselect exits power-down from any state.
// - Mask low lets write data be stored.
// - Mask high blocks write data.
// - Lower and upper masks act independently.
// - Idle or active qualification uses the addressed bank only.
// - Chip select high ignores every other command input.
// - Precharge: A10 low one bank, A10 high all banks.
// - Activate opens the given row in the selected bank.
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_decoder
  import dcd_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        CKE_IN,
  input  wire logic        CS_N_IN,
  input  wire logic        RAS_N_IN,
  input  wire logic        CAS_N_IN,
  input  wire logic        WE_N_IN,
  input  wire logic [2:0]  BA_IN,
  input  wire logic [12:0] A_IN,
  input  wire logic        ODT_IN,
  input  wire logic [1:0]  DM_IN,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic             DQ_OE_OUT,
  output logic      [1:0]  DQS_OUT,
  output logic      [1:0]  DQS_N_OUT,
  output logic             DQS_OE_OUT,
  output logic             TERM_EN_OUT,
  output logic             CMD_VALID_OUT,
  output dcd_cmd_e         CMD_CODE_OUT,
  output logic      [2:0]  CMD_BANK_OUT,
  output logic      [12:0] CMD_ADDR_OUT,
  output logic             SELF_REFRESH_OUT,
  output logic             POWER_DOWN_OUT
);

  // Link domain state
  logic            cke_prev;
  dcd_pwr_e        pwr;
  logic [7:0]      bank_open;
  logic [7:0][12:0] row;
  logic [12:0]     mr0;
  logic [12:0]     mr1;
  logic [12:0]     mr2;
  logic [2:0]      wr_left;
  logic [2:0]      wr_bank;
  logic [1:0]      wr_col;
  logic            wr_ap;
  logic [2:0]      rd_left;
  logic [2:0]      rd_bank;
  logic [1:0]      rd_col;
  logic            rd_ap;
  logic            rd_valid;
  logic [15:0]     odd_hold;
  logic [15:0]     dq_p;
  logic            dqs_p;
  logic            dq_oe;
  logic            term;
  logic            evt_tog;
  dcd_cmd_e        evt_code;
  logic [2:0]      evt_bank;
  logic [12:0]     evt_addr;
  logic            sr_lvl;
  logic            pd_lvl;

  logic            next_cke_prev;
  dcd_pwr_e        next_pwr;
  logic [7:0]      next_bank_open;
  logic [7:0][12:0] next_row;
  logic [12:0]     next_mr0;
  logic [12:0]     next_mr1;
  logic [12:0]     next_mr2;
  logic [2:0]      next_wr_left;
  logic [2:0]      next_wr_bank;
  logic [1:0]      next_wr_col;
  logic            next_wr_ap;
  logic [2:0]      next_rd_left;
  logic [2:0]      next_rd_bank;
  logic [1:0]      next_rd_col;
  logic            next_rd_ap;
  logic            next_rd_valid;
  logic [15:0]     next_odd_hold;
  logic [15:0]     next_dq_p;
  logic            next_dqs_p;
  logic            next_dq_oe;
  logic            next_term;
  logic            next_evt_tog;
  dcd_cmd_e        next_evt_code;
  logic [2:0]      next_evt_bank;
  logic [12:0]     next_evt_addr;
  logic            next_sr_lvl;
  logic            next_pd_lvl;

  // Falling-edge state
  logic [15:0]     dq_fall;
  logic [1:0]      dm_fall;
  logic [15:0]     dq_n;
  logic            dqs_n;
  logic [15:0]     next_dq_fall;
  logic [1:0]      next_dm_fall;
  logic [15:0]     next_dq_n;
  logic            next_dqs_n;

  // Decode helpers
  dcd_cmd_e        cmd;
  logic            enc_nop;
  logic            enc_nopdes;
  logic            enc_act;
  logic            enc_pre;
  logic            enc_rd;
  logic            enc_wr;
  logic            enc_mrs;
  logic            enc_ref;
  logic            enc_zq;
  logic            bank_idle;
  logic            chop;
  logic [2:0]      pairs;
  logic            rtt_on;

  logic                   mem_we;
  logic [`DCD_MEM_AW-1:0] mem_waddr;
  logic [`DCD_MEM_DW-1:0] mem_wdata;
  logic [3:0]             mem_wbe;
  logic [`DCD_MEM_AW-1:0] mem_raddr;
  logic [`DCD_MEM_DW-1:0] mem_rdata;

  // Core domain state
  logic            tog_s1;
  logic            tog_s2;
  logic            tog_s3;
  logic            sr_s1;
  logic            sr_s2;
  logic            pd_s1;
  logic            pd_s2;
  logic            next_valid;
  dcd_cmd_e        next_code;
  logic [2:0]      next_bank;
  logic [12:0]     next_addr;

  assign enc_nop    = !CS_N_IN && RAS_N_IN && CAS_N_IN && WE_N_IN;
  assign enc_nopdes = CS_N_IN || enc_nop;
  assign enc_act    = !CS_N_IN && !RAS_N_IN && CAS_N_IN && WE_N_IN;
  assign enc_pre    = !CS_N_IN && !RAS_N_IN && CAS_N_IN && !WE_N_IN;
  assign enc_rd     = !CS_N_IN && RAS_N_IN && !CAS_N_IN && WE_N_IN;
  assign enc_wr     = !CS_N_IN && RAS_N_IN && !CAS_N_IN && !WE_N_IN;
  assign enc_mrs    = !CS_N_IN && !RAS_N_IN && !CAS_N_IN && !WE_N_IN;
  assign enc_ref    = !CS_N_IN && !RAS_N_IN && !CAS_N_IN && WE_N_IN;
  assign enc_zq     = !CS_N_IN && RAS_N_IN && CAS_N_IN && !WE_N_IN;
  assign bank_idle  = !bank_open[BA_IN];

  // Burst length from mode register or A12
  assign chop  = (mr0[`DCD_MR_BL_HI:`DCD_MR_BL_LO] == `DCD_BL_OTF) ? !A_IN[`DCD_A_BC]
                                                                  : (mr0[`DCD_MR_BL_HI:`DCD_MR_BL_LO] == `DCD_BL_FIXED4);
  assign pairs = chop ? `DCD_PAIRS_BC4 : `DCD_PAIRS_BL8;

  assign rtt_on = mr1[`DCD_MR1_RTT0] || mr1[`DCD_MR1_RTT1] || mr1[`DCD_MR1_RTT2] ||
                  (mr2[`DCD_MR2_RTTW_HI:`DCD_MR2_RTTW_LO] != 2'h0);

  // Write pair commits at the rising edge that samples the odd beat
  assign mem_we    = (wr_left != 3'h0);
  assign mem_waddr = {wr_bank, row[wr_bank][1:0], wr_col};
  assign mem_wdata = {DQ_IN, dq_fall};
  assign mem_wbe   = ~{DM_IN[1], DM_IN[0], dm_fall[1], dm_fall[0]};
  assign mem_raddr = {rd_bank, row[rd_bank][1:0], rd_col};

  dcd_mem u_mem (
    .clk_in    (CK_IN),
    .we_in     (mem_we),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .wbe_in    (mem_wbe),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    next_cke_prev  = CKE_IN;
    next_pwr       = pwr;
    next_bank_open = bank_open;
    next_row       = row;
    next_mr0       = mr0;
    next_mr1       = mr1;
    next_mr2       = mr2;
    next_wr_left   = wr_left;
    next_wr_bank   = wr_bank;
    next_wr_col    = wr_col;
    next_wr_ap     = wr_ap;
    next_rd_left   = rd_left;
    next_rd_bank   = rd_bank;
    next_rd_col    = rd_col;
    next_rd_ap     = rd_ap;
    next_evt_tog   = evt_tog;
    next_evt_code  = evt_code;
    next_evt_bank  = evt_bank;
    next_evt_addr  = evt_addr;
    cmd            = DCD_CMD_NONE;

    // Burst progress and auto-precharge at the last pair
    if (wr_left != 3'h0) begin
      next_wr_left = wr_left - 3'h1;
      next_wr_col  = wr_col + 2'h1;
      if (wr_left == 3'h1 && wr_ap) begin
        next_bank_open[wr_bank] = 1'b0;
      end
    end
    if (rd_left != 3'h0) begin
      next_rd_left = rd_left - 3'h1;
      next_rd_col  = rd_col + 2'h1;
      if (rd_left == 3'h1 && rd_ap) begin
        next_bank_open[rd_bank] = 1'b0;
      end
    end

    // CKE judged over previous and current cycle
    if (cke_prev && CKE_IN) begin
      if (pwr == DCD_PW_ACTIVE) begin
        if (CS_N_IN) begin
          cmd = DCD_CMD_DES;
        end else if (enc_act && bank_idle) begin
          cmd = DCD_CMD_ACT;
        end else if (enc_pre) begin
          cmd = A_IN[`DCD_A_AP] ? DCD_CMD_PREA : DCD_CMD_PRE;
        end else if (enc_wr && !bank_idle) begin
          cmd = A_IN[`DCD_A_AP] ? DCD_CMD_WRA : DCD_CMD_WR;
        end else if (enc_rd && !bank_idle) begin
          cmd = A_IN[`DCD_A_AP] ? DCD_CMD_RDA : DCD_CMD_RD;
        end else if (enc_mrs && bank_idle) begin
          cmd = DCD_CMD_MRS;
        end else if (enc_ref && bank_idle) begin
          cmd = DCD_CMD_REF;
        end else if (enc_zq && bank_idle) begin
          cmd = A_IN[`DCD_A_AP] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
        end else if (enc_nop) begin
          cmd = DCD_CMD_NOP;
        end
      end
    end else if (cke_prev && !CKE_IN && pwr == DCD_PW_ACTIVE) begin
      if (enc_ref && bank_idle) begin
        cmd = DCD_CMD_SRE;
      end else if (enc_nopdes && bank_idle) begin
        cmd = DCD_CMD_PDE;
      end
    end else if (!cke_prev && CKE_IN && enc_nopdes) begin
      if (pwr == DCD_PW_SELF_REFRESH) begin
        cmd = DCD_CMD_SRX;
      end else if (pwr == DCD_PW_POWER_DOWN) begin
        cmd = DCD_CMD_PDX;
      end
    end

    case (cmd)
      DCD_CMD_ACT: begin
        next_bank_open[BA_IN] = 1'b1;
        next_row[BA_IN]       = A_IN;
      end
      DCD_CMD_PRE: begin
        next_bank_open[BA_IN] = 1'b0;
      end
      DCD_CMD_PREA: begin
        next_bank_open = 8'h00;
      end
      DCD_CMD_WR, DCD_CMD_WRA: begin
        next_wr_left = pairs;
        next_wr_bank = BA_IN;
        next_wr_col  = A_IN[2:1];
        next_wr_ap   = (cmd == DCD_CMD_WRA);
      end
      DCD_CMD_RD, DCD_CMD_RDA: begin
        next_rd_left = pairs;
        next_rd_bank = BA_IN;
        next_rd_col  = A_IN[2:1];
        next_rd_ap   = (cmd == DCD_CMD_RDA);
      end
      DCD_CMD_MRS: begin
        case (BA_IN[1:0])
          `DCD_MR_SEL0: next_mr0 = A_IN;
          `DCD_MR_SEL1: next_mr1 = A_IN;
          `DCD_MR_SEL2: next_mr2 = A_IN;
          default:      next_mr0 = mr0;
        endcase
      end
      DCD_CMD_SRE: next_pwr = DCD_PW_SELF_REFRESH;
      DCD_CMD_PDE: next_pwr = DCD_PW_POWER_DOWN;
      DCD_CMD_SRX, DCD_CMD_PDX: next_pwr = DCD_PW_ACTIVE;
      default: next_pwr = pwr;
    endcase

    // Report every real command to the core domain
    if (cmd != DCD_CMD_NONE && cmd != DCD_CMD_NOP && cmd != DCD_CMD_DES) begin
      next_evt_tog  = !evt_tog;
      next_evt_code = cmd;
      next_evt_bank = BA_IN;
      next_evt_addr = A_IN;
    end
  end

  // Read output and termination; output word is p xor n for dual-edge drive
  always_comb begin
    next_rd_valid = (rd_left != 3'h0);
    next_dq_oe    = rd_valid;
    next_dq_p     = rd_valid ? (mem_rdata[15:0] ^ dq_n) : dq_n;
    next_dqs_p    = rd_valid ? !dqs_n : dqs_n;
    next_odd_hold = mem_rdata[31:16];
    next_term     = ODT_IN && rtt_on;
    next_sr_lvl   = (next_pwr == DCD_PW_SELF_REFRESH);
    next_pd_lvl   = (next_pwr == DCD_PW_POWER_DOWN);
  end

  always_ff @(posedge CK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cke_prev  <= 1'b0;
      pwr       <= DCD_PW_ACTIVE;
      bank_open <= 8'h00;
      row       <= {8{`DCD_ROW_RST}};
      mr0       <= `DCD_MR_RST;
      mr1       <= `DCD_MR_RST;
      mr2       <= `DCD_MR_RST;
      wr_left   <= 3'h0;
      wr_bank   <= 3'h0;
      wr_col    <= 2'h0;
      wr_ap     <= 1'b0;
      rd_left   <= 3'h0;
      rd_bank   <= 3'h0;
      rd_col    <= 2'h0;
      rd_ap     <= 1'b0;
      rd_valid  <= 1'b0;
      odd_hold  <= 16'h0000;
      dq_p      <= 16'h0000;
      dqs_p     <= 1'b0;
      dq_oe     <= 1'b0;
      term      <= 1'b0;
      evt_tog   <= 1'b0;
      evt_code  <= DCD_CMD_NONE;
      evt_bank  <= 3'h0;
      evt_addr  <= 13'h0000;
      sr_lvl    <= 1'b0;
      pd_lvl    <= 1'b0;
    end else begin
      cke_prev  <= next_cke_prev;
      pwr       <= next_pwr;
      bank_open <= next_bank_open;
      row       <= next_row;
      mr0       <= next_mr0;
      mr1       <= next_mr1;
      mr2       <= next_mr2;
      wr_left   <= next_wr_left;
      wr_bank   <= next_wr_bank;
      wr_col    <= next_wr_col;
      wr_ap     <= next_wr_ap;
      rd_left   <= next_rd_left;
      rd_bank   <= next_rd_bank;
      rd_col    <= next_rd_col;
      rd_ap     <= next_rd_ap;
      rd_valid  <= next_rd_valid;
      odd_hold  <= next_odd_hold;
      dq_p      <= next_dq_p;
      dqs_p     <= next_dqs_p;
      dq_oe     <= next_dq_oe;
      term      <= next_term;
      evt_tog   <= next_evt_tog;
      evt_code  <= next_evt_code;
      evt_bank  <= next_evt_bank;
      evt_addr  <= next_evt_addr;
      sr_lvl    <= next_sr_lvl;
      pd_lvl    <= next_pd_lvl;
    end
  end

  // Falling edge: capture even write beat, launch odd read beat
  always_comb begin
    next_dq_fall = DQ_IN;
    next_dm_fall = DM_IN;
    next_dq_n    = dq_oe ? (odd_hold ^ dq_p) : dq_p;
    next_dqs_n   = dqs_p;
  end

  always_ff @(negedge CK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dq_fall <= 16'h0000;
      dm_fall <= 2'h0;
      dq_n    <= 16'h0000;
      dqs_n   <= 1'b0;
    end else begin
      dq_fall <= next_dq_fall;
      dm_fall <= next_dm_fall;
      dq_n    <= next_dq_n;
      dqs_n   <= next_dqs_n;
    end
  end

  assign DQ_OUT      = dq_p ^ dq_n;
  assign DQ_OE_OUT   = dq_oe;
  assign DQS_OUT     = {2{dqs_p ^ dqs_n}};
  assign DQS_N_OUT   = {2{!(dqs_p ^ dqs_n)}};
  assign DQS_OE_OUT  = dq_oe;
  assign TERM_EN_OUT = term;

  // Core domain: toggle crossing for command events, two flops for levels
  always_comb begin
    next_valid = tog_s2 ^ tog_s3;
    next_code  = next_valid ? evt_code : CMD_CODE_OUT;
    next_bank  = next_valid ? evt_bank : CMD_BANK_OUT;
    next_addr  = next_valid ? evt_addr : CMD_ADDR_OUT;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tog_s1           <= 1'b0;
      tog_s2           <= 1'b0;
      tog_s3           <= 1'b0;
      sr_s1            <= 1'b0;
      sr_s2            <= 1'b0;
      pd_s1            <= 1'b0;
      pd_s2            <= 1'b0;
      CMD_VALID_OUT    <= 1'b0;
      CMD_CODE_OUT     <= DCD_CMD_NONE;
      CMD_BANK_OUT     <= 3'h0;
      CMD_ADDR_OUT     <= 13'h0000;
      SELF_REFRESH_OUT <= 1'b0;
      POWER_DOWN_OUT   <= 1'b0;
    end else begin
      tog_s1           <= evt_tog;
      tog_s2           <= tog_s1;
      tog_s3           <= tog_s2;
      sr_s1            <= sr_lvl;
      sr_s2            <= sr_s1;
      pd_s1            <= pd_lvl;
      pd_s2            <= pd_s1;
      CMD_VALID_OUT    <= next_valid;
      CMD_CODE_OUT     <= next_code;
      CMD_BANK_OUT     <= next_bank;
      CMD_ADDR_OUT     <= next_addr;
      SELF_REFRESH_OUT <= sr_s2;
      POWER_DOWN_OUT   <= pd_s2;
    end
  end

endmodule

// >>> bench/dcd_decoder_chk.sv
// Concurrent checks on decoder outputs, bound to the decoder.
// Assumes core and link resets are released together.
`timescale 1ns/1ps
module dcd_decoder_chk
  import dcd_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       CK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic       ODT_IN,
  input  wire logic       DQ_OE_OUT,
  input  wire logic [1:0] DQS_OUT,
  input  wire logic [1:0] DQS_N_OUT,
  input  wire logic       DQS_OE_OUT,
  input  wire logic       TERM_EN_OUT,
  input  wire logic       CMD_VALID_OUT,
  input  wire dcd_cmd_e   CMD_CODE_OUT
);
  valid_pulse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT |=> !CMD_VALID_OUT) else $error("valid longer than a cycle");
  real_cmd_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT |-> !(CMD_CODE_OUT inside {DCD_CMD_NONE, DCD_CMD_NOP, DCD_CMD_DES}))
    else $error("idle code reported");
  code_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !CMD_VALID_OUT |-> $stable(CMD_CODE_OUT)) else $error("code moved without valid");
  read_oe_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT && CMD_CODE_OUT inside {DCD_CMD_RD, DCD_CMD_RDA} |-> ##[15:30] DQ_OE_OUT)
    else $error("no read data after read");
  strobe_pair_a: assert property (@(posedge CK_IN) disable iff (!RESET_N_IN)
    DQS_OE_OUT == DQ_OE_OUT && DQS_N_OUT == ~DQS_OUT) else $error("strobe pair mismatch");
  dqs_low_a: assert property (@(posedge CK_IN) disable iff (!RESET_N_IN)
    DQS_OUT == 2'h0) else $error("strobe high in low half");
  dqs_high_a: assert property (@(negedge CK_IN) disable iff (!RESET_N_IN)
    DQS_OUT == {2{DQ_OE_OUT}}) else $error("strobe wrong in high half");
  term_off_a: assert property (@(posedge CK_IN) disable iff (!RESET_N_IN)
    !$past(ODT_IN) |-> !TERM_EN_OUT) else $error("termination without request");
  cover property (@(posedge CLK_IN) CMD_VALID_OUT && CMD_CODE_OUT == DCD_CMD_WRA);
  cover property (@(posedge CLK_IN) CMD_VALID_OUT && CMD_CODE_OUT == DCD_CMD_RDA);
  cover property (@(posedge CLK_IN) CMD_VALID_OUT && CMD_CODE_OUT == DCD_CMD_SRE);
endmodule

bind dcd_decoder dcd_decoder_chk u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CK_IN(CK_IN), .RESET_N_IN(RESET_N_IN), .ODT_IN(ODT_IN),
  .DQ_OE_OUT(DQ_OE_OUT), .DQS_OUT(DQS_OUT), .DQS_N_OUT(DQS_N_OUT), .DQS_OE_OUT(DQS_OE_OUT),
  .TERM_EN_OUT(TERM_EN_OUT), .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_CODE_OUT(CMD_CODE_OUT)
);

// >>> bench/dcd_ctrl_model.sv
// Controller model: command, address, masks and write data on the link clock.
// Assumes commands are taken on the rising link edge.
`timescale 1ns/1ps
module dcd_ctrl_model (
  input  wire logic        ck_in,
  input  wire logic [15:0] dq_in,
  output logic             cke_out,
  output logic [3:0]       cmd_out,
  output logic [2:0]       ba_out,
  output logic [12:0]      a_out,
  output logic [1:0]       dm_out,
  output logic [15:0]      dq_out
);
  initial begin
    cke_out = 1'b0;
    cmd_out = 4'hF;
    ba_out = 3'h0;
    a_out = 13'h0000;
    dm_out = 2'h0;
    dq_out = 16'h0000;
  end
  // One cycle of command, then no-op with address inverted
  task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(posedge ck_in);
    cke_out <= k;
    cmd_out <= c;
    ba_out <= b;
    a_out <= a;
    @(posedge ck_in);
    cmd_out <= 4'h7;
    a_out <= ~a;
  endtask
  // Beats from the edge the write is taken; lines inverted once released
  task automatic burst(input int n, input logic [127:0] d, input logic [15:0] m);
    repeat (2) @(posedge ck_in);
    for (int i = 0; i < n; i++) begin
      if (i[0])
        @(negedge ck_in);
      else if (i > 0)
        @(posedge ck_in);
      dq_out <= d[16*i +: 16];
      dm_out <= m[2*i +: 2];
    end
    @(posedge ck_in);
    dq_out <= ~dq_out;
    dm_out <= ~dm_out;
  endtask
  // Read beats sampled mid half-cycle
  task automatic capture(input int n, output logic [127:0] q);
    q = '0;
    repeat (3) @(posedge ck_in);
    for (int i = 0; i < n; i++) begin
      if (i[0])
        @(negedge ck_in);
      else
        @(posedge ck_in);
      #16 q[16*i +: 16] = dq_in;
    end
  endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the command decoder with the controller model.
// Assumes package, decoder, checker and model compiled first.
`timescale 1ns/1ps
module testbench;
  import dcd_pkg::*;
  localparam logic [16:0] MRT [6] = '{17'h00001, 17'h12004, 17'h02000, 17'h14200, 17'h04000, 17'h12200};
  logic         clk, ck, rst, rst_n, odt, cke, valid, term, sr, pd;
  logic [3:0]   c;
  logic [2:0]   ba, cba, b;
  logic [12:0]  a, cad, row, ra;
  logic [1:0]   dm;
  logic [15:0]  dqi, dqo;
  logic [7:0]   mk;
  logic [31:0]  seed, r;
  logic [127:0] d, d2, q;
  dcd_cmd_e     code;
  int           error_cnt, n_compared;

  dcd_ctrl_model ctl (.ck_in(ck), .dq_in(dqo), .cke_out(cke), .cmd_out(c), .ba_out(ba), .a_out(a),
                      .dm_out(dm), .dq_out(dqi));
  dcd_decoder DUT (
    .CLK_IN(clk), .RST_IN(rst), .CK_IN(ck), .RESET_N_IN(rst_n), .CKE_IN(cke), .CS_N_IN(c[3]),
    .RAS_N_IN(c[2]), .CAS_N_IN(c[1]), .WE_N_IN(c[0]), .BA_IN(ba), .A_IN(a), .ODT_IN(odt), .DM_IN(dm),
    .DQ_IN(dqi), .DQ_OUT(dqo), .DQ_OE_OUT(), .DQS_OUT(), .DQS_N_OUT(), .DQS_OE_OUT(),
    .TERM_EN_OUT(term), .CMD_VALID_OUT(valid), .CMD_CODE_OUT(code), .CMD_BANK_OUT(cba),
    .CMD_ADDR_OUT(cad), .SELF_REFRESH_OUT(sr), .POWER_DOWN_OUT(pd)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #32 ck = ~ck;
  end
  initial begin
    #30000;
    error_cnt++;
    summarize();
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Masked bytes keep the old beat
  function automatic logic [127:0] merge(input logic [127:0] o, input logic [127:0] w, input logic [15:0] m);
    merge = o;
    for (int i = 0; i < 16; i++)
      if (!m[i])
        merge[8*i +: 8] = w[8*i +: 8];
  endfunction

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Issue one command and watch the report window
  task automatic cmd(input logic k, input logic [3:0] cc, input logic [2:0] bk, input logic [12:0] ad,
                     input dcd_cmd_e exp);
    logic        hit;
    logic [20:0] got;
    hit = 1'b0;
    got = '0;
    ctl.issue(k, cc, bk, ad);
    repeat (12) begin
      @(posedge clk);
      #1;
      if (valid === 1'b1) begin
        hit = 1'b1;
        got = {code, cba, cad};
      end
    end
    check("pulse", hit, exp != DCD_CMD_NONE);
    if (hit)
      check("command", got, {exp, bk, ad});
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    seed = 32'h00010451;
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    rst_n = 1'b0;
    odt = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rst_n <= 1'b1;
    @(posedge ck);
    odt <= 1'b1;
    ctl.issue(1'b1, 4'hF, 3'h0, 13'h0000);
    for (int i = 0; i < 6; i++) begin
      cmd(1, 4'h0, MRT[i][15:13], MRT[i][12:0], DCD_CMD_MRS);
      @(negedge ck);
      check("termination", term, MRT[i][16]);
    end
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      b = r[2:0];
      row = r[15:3];
      mk = (k == 3) ? 8'hFF : r[23:16];
      d = {rnd(), rnd(), rnd(), rnd()};
      d2 = {rnd(), rnd(), rnd(), rnd()};
      ra = k[0] ? 13'h1000 : 13'h1400;
      cmd(1, 4'h3, b, row, DCD_CMD_ACT);
      fork
        ctl.burst(8, d, 16'h0000);
        cmd(1, 4'h4, b, 13'h1000, DCD_CMD_WR);
      join
      fork
        ctl.burst(4, d2, {8'h00, mk});
        cmd(1, 4'h4, b, 13'h0400, DCD_CMD_WRA);
      join
      cmd(1, 4'h7, b, row, DCD_CMD_NONE);
      cmd(1, 4'h5, b, 13'h1000, DCD_CMD_NONE);
      cmd(1, 4'h3, b, row, DCD_CMD_ACT);
      fork
        ctl.capture(8, q);
        cmd(1, 4'h5, b, ra, k[0] ? DCD_CMD_RD : DCD_CMD_RDA);
      join
      check("read data", q, merge(d, d2, {8'hFF, mk}));
      if (k[0])
        cmd(1, 4'h2, b, k[1] ? 13'h0400 : 13'h0000, k[1] ? DCD_CMD_PREA : DCD_CMD_PRE);
    end
    cmd(1, 4'hB, 3'h0, 13'h0000, DCD_CMD_NONE);
    cmd(1, 4'h1, 3'h0, 13'h0000, DCD_CMD_REF);
    cmd(1, 4'h6, 3'h1, 13'h0400, DCD_CMD_ZQCL);
    cmd(1, 4'h6, 3'h1, 13'h0000, DCD_CMD_ZQCS);
    cmd(0, 4'h1, 3'h2, 13'h0000, DCD_CMD_SRE);
    check("self refresh", sr, 1'b1);
    cmd(0, 4'h3, 3'h2, 13'h0000, DCD_CMD_NONE);
    cmd(1, 4'h7, 3'h2, 13'h0000, DCD_CMD_SRX);
    check("self refresh", sr, 1'b0);
    cmd(0, 4'hF, 3'h3, 13'h0000, DCD_CMD_PDE);
    check("power down", pd, 1'b1);
    cmd(1, 4'hF, 3'h3, 13'h0000, DCD_CMD_PDX);
    check("power down", pd, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    rst_n <= 1'b0;
    #2;
    check("termination", term, 1'b0);
    summarize();
  end
endmodule
